// ### pkg/ltmc_regs.svh
// Purpose: Timing constants of the LIN mode control block
// Assumes: core clock of 20 MHz
// Notes:   Least times round up to whole cycles
`ifndef LTMC_REGS_SVH
`define LTMC_REGS_SVH

`define LTC_CLK_MHZ   20
`define LTC_DEB_NS    500
`define LTC_DEB_CYC   ((`LTC_DEB_NS * `LTC_CLK_MHZ + 999) / 1000)
`define LTC_REM_US    30
`define LTC_REM_CYC   (`LTC_REM_US * `LTC_CLK_MHZ)
`define LTC_LOC_US    10
`define LTC_LOC_CYC   (`LTC_LOC_US * `LTC_CLK_MHZ)
`define LTC_SLEEP_MS  350
`define LTC_SLEEP_CYC (`LTC_SLEEP_MS * `LTC_CLK_MHZ * 1000)
`define LTC_TXTO_MS   27
`define LTC_TXTO_CYC  (`LTC_TXTO_MS * `LTC_CLK_MHZ * 1000)
`define LTC_CNT_W     23
`define LTC_WK_W      10
`define LTC_DEB_W     4
`define LTC_FLT_RST   2'h2

`endif

// ### pkg/ltmc_pkg.sv
// Purpose: Types of the LIN mode control block
// Assumes: nothing
// Notes:   Mode states carry no fixed codes
package ltmc_pkg;
   typedef enum logic [1:0] {
      mode_standby,
      mode_normal,
      mode_sleep
   } ltmc_mode_type;
endpackage : ltmc_pkg

// ### hw/ltmc_core.sv
// Purpose: Mode sequencing, filters and time-outs of a LIN transceiver
// Assumes: all pin inputs synchronous to core_clk; bus_rx high is recessive
// Notes:   Open-drain and floating pins use value plus active-low enable
`timescale 1ns/100ps
`include "ltmc_regs.svh"

module ltmc_core #(
   parameter int unsigned SLEEP_CYC = `LTC_SLEEP_CYC,
   parameter int unsigned TXTO_CYC  = `LTC_TXTO_CYC
) (
   input  wire logic core_clk,
   input  wire logic rst_b,
   input  wire logic mode_en,
   input  wire logic txd_in,
   input  wire logic wake_in,
   input  wire logic bus_rx,
   input  wire logic therm_ovl,
   output logic      rxd_o,
   output logic      rxd_oe_b,
   output logic      txd_flag_o,
   output logic      txd_flag_oe_b,
   output logic      regulator_inhibit_output,
   output logic      regulator_inhibit_oe_b,
   output logic      bus_tx_dom,
   output logic      slave_term_en
);

   localparam logic [`LTC_CNT_W-1:0] SLEEP_LIM = `LTC_CNT_W'(SLEEP_CYC);
   localparam logic [`LTC_CNT_W-1:0] TXTO_LIM  = `LTC_CNT_W'(TXTO_CYC);
   localparam logic [`LTC_WK_W-1:0]  REM_LIM   = `LTC_WK_W'(`LTC_REM_CYC);
   localparam logic [`LTC_WK_W-1:0]  LOC_LIM   = `LTC_WK_W'(`LTC_LOC_CYC);
   localparam logic [`LTC_DEB_W-1:0] DEB_LIM   = `LTC_DEB_W'(`LTC_DEB_CYC);
   localparam logic [1:0]            FLT_RST   = `LTC_FLT_RST;

   ltmc_pkg::ltmc_mode_type mode_q;
   ltmc_pkg::ltmc_mode_type mode_d;
   logic                  en_prev_q;
   logic                  txd_prev_q;
   logic [`LTC_CNT_W-1:0] sleep_cnt_q;
   logic [`LTC_CNT_W-1:0] to_cnt_q;
   logic [`LTC_WK_W-1:0]  rem_cnt_q;
   logic [`LTC_WK_W-1:0]  loc_cnt_q;
   logic                  rem_seen_q;
   logic                  loc_seen_q;
   logic                  rem_arm_q;
   logic                  wake_req_q;
   logic                  wake_loc_q;
   logic                  tx_en_q;
   logic                  therm_lock_q;
   logic [1:0]            raw;
   logic [1:0]            flt;
   wire                   en_flt;
   wire                   rx_flt;
   wire                   in_sby;
   wire                   in_nrm;
   wire                   in_slp;
   wire                   en_rise;
   wire                   txd_fall;
   wire                   sleep_hit;
   wire                   rem_full;
   wire                   rem_hit;
   wire                   loc_hit;
   wire                   wake_set;
   wire                   to_hit;
   wire                   nrm_next;

   // Debounce of mode input and bus level, one filter per bit
   assign raw = {bus_rx, mode_en};
   for (genvar i = 0; i < 2; i++) begin : g_deb
      logic [`LTC_DEB_W-1:0] cnt_q;
      logic                  q;
      always_ff @(posedge core_clk or negedge rst_b) begin
         if (!rst_b) begin
            cnt_q <= '0;
            q     <= FLT_RST[i];
         end else if (raw[i] == q) begin
            cnt_q <= '0;
         end else if (cnt_q == DEB_LIM - `LTC_DEB_W'(1)) begin
            cnt_q <= '0;
            q     <= raw[i];
         end else begin
            cnt_q <= cnt_q + `LTC_DEB_W'(1);
         end
      end
      assign flt[i] = q;
   end

   // Decoded state and events
   assign en_flt    = flt[0];
   assign rx_flt    = flt[1];
   assign in_sby    = (mode_q == ltmc_pkg::mode_standby);
   assign in_nrm    = (mode_q == ltmc_pkg::mode_normal);
   assign in_slp    = (mode_q == ltmc_pkg::mode_sleep);
   assign en_rise   = mode_en & ~en_prev_q;
   assign txd_fall  = ~txd_in & txd_prev_q;
   assign sleep_hit = in_sby & (sleep_cnt_q == SLEEP_LIM - `LTC_CNT_W'(1));
   assign rem_full  = rem_seen_q & ~bus_rx & (rem_cnt_q == REM_LIM - `LTC_WK_W'(1));
   assign rem_hit   = in_slp & rem_arm_q & bus_rx;
   assign loc_hit   = in_slp & loc_seen_q & ~wake_in
                    & (loc_cnt_q == LOC_LIM - `LTC_WK_W'(1));
   assign wake_set  = (rem_hit | loc_hit) & ~en_flt;
   assign to_hit    = tx_en_q & ~txd_in & (to_cnt_q == TXTO_LIM - `LTC_CNT_W'(1));
   assign nrm_next  = (mode_d == ltmc_pkg::mode_normal);

   // Mode sequencing
   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         ltmc_pkg::mode_standby: begin
            if (en_flt) begin
               mode_d = ltmc_pkg::mode_normal;
            end else if (sleep_hit) begin
               mode_d = ltmc_pkg::mode_sleep;
            end
         end
         ltmc_pkg::mode_normal: begin
            if (!en_flt) begin
               mode_d = ltmc_pkg::mode_sleep;
            end
         end
         ltmc_pkg::mode_sleep: begin
            if (en_flt) begin
               mode_d = ltmc_pkg::mode_normal;
            end else if (rem_hit || loc_hit) begin
               mode_d = ltmc_pkg::mode_standby;
            end
         end
         default: begin
            mode_d = ltmc_pkg::mode_standby;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_q     <= ltmc_pkg::mode_standby;
         en_prev_q  <= 1'b0;
         txd_prev_q <= 1'b0;
      end else begin
         mode_q     <= mode_d;
         en_prev_q  <= mode_en;
         txd_prev_q <= txd_in;
      end
   end

   // Standby-to-sleep timer, restarts on every standby entry
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sleep_cnt_q <= '0;
      end else if (!in_sby || mode_d != ltmc_pkg::mode_standby) begin
         sleep_cnt_q <= '0;
      end else begin
         sleep_cnt_q <= sleep_cnt_q + `LTC_CNT_W'(1);
      end
   end

   // Remote wake filter: recessive seen, dominant held, then recessive
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rem_seen_q <= 1'b0;
         rem_cnt_q  <= '0;
         rem_arm_q  <= 1'b0;
      end else if (!in_slp) begin
         rem_seen_q <= 1'b0;
         rem_cnt_q  <= '0;
         rem_arm_q  <= 1'b0;
      end else begin
         rem_seen_q <= rem_seen_q | bus_rx;
         rem_arm_q  <= rem_arm_q | rem_full;
         rem_cnt_q  <= (bus_rx || !rem_seen_q || rem_full) ? '0
                     : rem_cnt_q + `LTC_WK_W'(1);
      end
   end

   // Local wake filter: falling wake pin held low
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         loc_seen_q <= 1'b0;
         loc_cnt_q  <= '0;
      end else if (!in_slp) begin
         loc_seen_q <= 1'b0;
         loc_cnt_q  <= '0;
      end else begin
         loc_seen_q <= loc_seen_q | wake_in;
         loc_cnt_q  <= (wake_in || !loc_seen_q || loc_hit) ? '0
                     : loc_cnt_q + `LTC_WK_W'(1);
      end
   end

   // Wake request and source flags, set wins over clear
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wake_req_q <= 1'b0;
         wake_loc_q <= 1'b0;
      end else begin
         wake_req_q <= wake_set | (wake_req_q & ~en_rise & ~in_nrm);
         wake_loc_q <= (wake_set & loc_hit)
                     | (wake_loc_q & ~en_rise & ~in_nrm);
      end
   end

   // Transmit path enable and dominant time-out
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_en_q  <= 1'b0;
         to_cnt_q <= '0;
      end else begin
         tx_en_q  <= in_nrm & nrm_next & (tx_en_q ? ~to_hit : txd_in);
         if (!tx_en_q || txd_in) begin
            to_cnt_q <= '0;
         end else if (txd_fall) begin
            to_cnt_q <= `LTC_CNT_W'(1);
         end else if (!to_hit) begin
            to_cnt_q <= to_cnt_q + `LTC_CNT_W'(1);
         end
      end
   end

   // Thermal lock held until recovery and next dominant edge
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         therm_lock_q <= 1'b0;
      end else begin
         therm_lock_q <= therm_ovl | (therm_lock_q & ~txd_fall);
      end
   end

   // Pin drive decode
   assign rxd_o                    = 1'b0;
   assign rxd_oe_b                 = in_nrm ? rx_flt : ~(in_sby & wake_req_q);
   assign txd_flag_o               = 1'b0;
   assign txd_flag_oe_b            = ~(in_sby & wake_loc_q);
   assign regulator_inhibit_output = 1'b1;
   assign regulator_inhibit_oe_b   = in_slp;
   assign slave_term_en            = ~in_slp;
   assign bus_tx_dom = in_nrm & tx_en_q & ~therm_lock_q & ~txd_in;

   // Checks
   inh_driven_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      !in_slp |-> !regulator_inhibit_oe_b)
      else $error("inhibit not driven outside sleep");
   sleep_float_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      in_slp |-> rxd_oe_b && regulator_inhibit_oe_b && txd_flag_oe_b && !slave_term_en)
      else $error("pins not released in sleep");
   sleep_timer_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (in_sby && !en_flt && sleep_cnt_q == SLEEP_LIM - `LTC_CNT_W'(1)) |=> in_slp)
      else $error("standby timer did not reach sleep");
   sby_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      in_sby |-> !bus_tx_dom && (rxd_oe_b == !wake_req_q))
      else $error("standby drives bus or receive pin");
   wake_clear_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (en_rise && !wake_set) |=> !wake_req_q && !wake_loc_q)
      else $error("mode edge did not clear wake flags");
   wake_entry_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (in_slp && wake_set) |=> in_sby && !rxd_oe_b)
      else $error("wake did not enter standby low");
   rem_filter_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      $rose(rem_arm_q) |-> $past(rem_cnt_q) == REM_LIM - `LTC_WK_W'(1) && $past(!bus_rx))
      else $error("remote filter armed early");
   loc_filter_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      $rose(wake_loc_q) |-> $past(loc_cnt_q) == LOC_LIM - `LTC_WK_W'(1) && $past(!wake_in))
      else $error("local wake accepted early");
   tx_enable_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      $rose(tx_en_q) |-> $past(txd_in) && in_nrm)
      else $error("transmit path enabled without recessive");
   tx_timeout_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      to_hit |=> !tx_en_q ##1 !bus_tx_dom)
      else $error("time-out did not drop transmit path");
   rx_pass_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      in_nrm |-> rxd_oe_b == rx_flt)
      else $error("receive pin not following bus");
   rx_debounce_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      $changed(rx_flt) |-> $past(bus_rx, 1) == rx_flt && $past(bus_rx, 10) == rx_flt)
      else $error("receive filter changed early");
   src_flag_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (in_sby && wake_req_q) |-> txd_flag_oe_b == !wake_loc_q)
      else $error("wake source flag wrong");
   norm_sleep_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (in_nrm && !en_flt) |=> in_slp)
      else $error("normal mode ignored low mode input");
   therm_block_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      therm_ovl |=> !bus_tx_dom)
      else $error("transmitter active under overload");

   // Further checks on mode filter, transmit path, slave termination and wake flags
   mode_debounce_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      $changed(en_flt) |-> $past(mode_en, 1) == en_flt && $past(mode_en, 10) == en_flt)
      else $error("mode filter changed early");
   tx_normal_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      !in_nrm |-> !bus_tx_dom)
      else $error("bus driven outside normal mode");
   term_on_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      !in_slp |-> slave_term_en)
      else $error("slave termination off outside sleep");
   to_restart_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (tx_en_q && txd_fall) |=> to_cnt_q == `LTC_CNT_W'(1))
      else $error("time-out not restarted on falling edge");
   tx_recessive_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (!tx_en_q && !txd_in) |=> !tx_en_q)
      else $error("transmit path enabled on dominant");
   rem_no_flag_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (in_slp && rem_hit && !loc_hit && !en_flt) |=> !wake_loc_q)
      else $error("remote wake set source flag");
   wake_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (in_sby && wake_req_q && !en_rise) |=> wake_req_q)
      else $error("wake request dropped in standby");

   local_wake_c: cover property (@(posedge core_clk) disable iff (!rst_b)
      in_slp && loc_hit ##1 in_sby ##[1:20] in_nrm);
   remote_wake_c: cover property (@(posedge core_clk) disable iff (!rst_b)
      in_slp && rem_hit ##1 in_sby);
   tx_timeout_c: cover property (@(posedge core_clk) disable iff (!rst_b)
      to_hit ##[1:5] tx_en_q);
   sby_sleep_c: cover property (@(posedge core_clk) disable iff (!rst_b)
      sleep_hit ##1 in_slp);
   therm_release_c: cover property (@(posedge core_clk) disable iff (!rst_b)
      therm_lock_q ##1 !therm_lock_q);

endmodule : ltmc_core

// ### verif/ltmc_host_model.sv
// Purpose: Host controller model on the mode and transmit pins
// Assumes: bench gives levels by mode_req and tx_req
// Notes:   Receive pin has a pull-up, so a released pin reads high
`timescale 1ns/100ps

module ltmc_host_model (
   input  wire logic core_clk,
   input  wire logic rst_b,
   input  wire logic mode_req,
   input  wire logic tx_req,
   input  wire logic rxd_o,
   input  wire logic rxd_oe_b,
   output logic      mode_en,
   output logic      txd_in,
   output logic      rxd_pin
);
   // Pin drivers change just after the edge
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_en <= 1'h0;
         txd_in  <= 1'h1;
      end else begin
         mode_en <= mode_req;
         txd_in  <= tx_req;
      end
   end

   // Pull-up resolves the open-drain receive pin
   assign rxd_pin = rxd_oe_b ? 1'h1 : rxd_o;
endmodule : ltmc_host_model

// ### verif/ltmc_core_tb_top.sv
// Purpose: Self-checking bench for the LIN mode control block
// Assumes: shortened sleep and time-out counts
// Notes:   Outputs are looked at on the falling edge
`timescale 1ns/100ps

module ltmc_core_tb_top;
   localparam int SLP = 200;
   localparam int TTO = 100;
   logic core_clk = 1'h0;
   logic rst_b    = 1'h0;
   logic mode_req = 1'h0;
   logic tx_req   = 1'h1;
   logic wake_in  = 1'h1;
   logic bus_rx   = 1'h1;
   logic therm_ovl = 1'h0;
   logic mode_en, txd_in, rxd_o, rxd_oe_b, rxd_pin, txd_flag_o, txd_flag_oe_b;
   logic inh_o, inh_oe_b, bus_tx_dom, slave_term_en;
   int   n_mismatch = 0;
   int   samples_checked = 0;

   // 20 MHz clock
   always #25 core_clk = ~core_clk;

   ltmc_core #(.SLEEP_CYC(SLP), .TXTO_CYC(TTO)) ltmc_core_inst (
      .core_clk(core_clk), .rst_b(rst_b), .mode_en(mode_en), .txd_in(txd_in),
      .wake_in(wake_in), .bus_rx(bus_rx), .therm_ovl(therm_ovl), .rxd_o(rxd_o),
      .rxd_oe_b(rxd_oe_b), .txd_flag_o(txd_flag_o), .txd_flag_oe_b(txd_flag_oe_b),
      .regulator_inhibit_output(inh_o), .regulator_inhibit_oe_b(inh_oe_b),
      .bus_tx_dom(bus_tx_dom), .slave_term_en(slave_term_en));

   ltmc_host_model ltmc_host_model_inst (
      .core_clk(core_clk), .rst_b(rst_b), .mode_req(mode_req), .tx_req(tx_req),
      .rxd_o(rxd_o), .rxd_oe_b(rxd_oe_b), .mode_en(mode_en), .txd_in(txd_in),
      .rxd_pin(rxd_pin));

   task automatic chk(input string what, input logic seen, input logic exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %b seen %b", what, exp, seen);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc

   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim

   // Standby timer runs out into sleep
   task automatic t_sleep_timer();
      cyc(SLP - 10); @(negedge core_clk);
      chk("inh_oe_b", inh_oe_b, 1'h0);
      cyc(20); @(negedge core_clk);
      chk("inh_oe_b", inh_oe_b, 1'h1);
      chk("term", slave_term_en, 1'h0);
      chk("rxd_oe_b", rxd_oe_b, 1'h1);
      chk("bus_tx", bus_tx_dom, 1'h0);
   endtask : t_sleep_timer

   // Short then long low on the wake pin
   task automatic t_local_wake();
      cyc(1); wake_in <= 1'h0;
      cyc(100); wake_in <= 1'h1;
      cyc(5); @(negedge core_clk);
      chk("inh_oe_b", inh_oe_b, 1'h1);
      cyc(1); wake_in <= 1'h0;
      cyc(205); @(negedge core_clk);
      chk("inh_oe_b", inh_oe_b, 1'h0);
      chk("rxd_pin", rxd_pin, 1'h0);
      chk("flag_oe_b", txd_flag_oe_b, 1'h0);
      chk("flag_o", txd_flag_o, 1'h0);
      cyc(1); wake_in <= 1'h1;
   endtask : t_local_wake

   // Mode rise clears wake flags at once
   task automatic t_mode_rise();
      cyc(1); mode_req <= 1'h1;
      cyc(3); @(negedge core_clk);
      chk("rxd_pin", rxd_pin, 1'h1);
      chk("flag_oe_b", txd_flag_oe_b, 1'h1);
      cyc(14);
   endtask : t_mode_rise

   // Receive filter rejects a short dominant
   task automatic t_receive();
      cyc(1); bus_rx <= 1'h0;
      cyc(5); @(negedge core_clk);
      chk("rxd_pin", rxd_pin, 1'h1);
      cyc(1); bus_rx <= 1'h1;
      cyc(15); bus_rx <= 1'h0;
      cyc(15); @(negedge core_clk);
      chk("rxd_pin", rxd_pin, 1'h0);
      cyc(1); bus_rx <= 1'h1;
      cyc(15); @(negedge core_clk);
      chk("rxd_pin", rxd_pin, 1'h1);
   endtask : t_receive

   // Dominant time-out, re-enable and restart
   task automatic t_transmit();
      cyc(1); tx_req <= 1'h0;
      cyc(3); @(negedge core_clk);
      chk("bus_tx", bus_tx_dom, 1'h1);
      cyc(TTO + 10); @(negedge core_clk);
      chk("bus_tx", bus_tx_dom, 1'h0);
      cyc(1); tx_req <= 1'h1;
      cyc(3); tx_req <= 1'h0;
      cyc(75); tx_req <= 1'h1;
      cyc(2); tx_req <= 1'h0;
      cyc(75); @(negedge core_clk);
      chk("bus_tx", bus_tx_dom, 1'h1);
      cyc(1); tx_req <= 1'h1;
   endtask : t_transmit

   // Overload blocks until the next dominant edge
   task automatic t_thermal();
      cyc(3); therm_ovl <= 1'h1; tx_req <= 1'h0;
      cyc(3); @(negedge core_clk);
      chk("bus_tx", bus_tx_dom, 1'h0);
      cyc(1); therm_ovl <= 1'h0;
      cyc(3); @(negedge core_clk);
      chk("bus_tx", bus_tx_dom, 1'h0);
      cyc(1); tx_req <= 1'h1;
      cyc(2); tx_req <= 1'h0;
      cyc(3); @(negedge core_clk);
      chk("bus_tx", bus_tx_dom, 1'h1);
      cyc(1); tx_req <= 1'h1;
   endtask : t_thermal

   // Mode low with dominant pins, then remote wake
   task automatic t_remote();
      cyc(3); bus_rx <= 1'h0; tx_req <= 1'h0; mode_req <= 1'h0;
      cyc(20); @(negedge core_clk);
      chk("inh_oe_b", inh_oe_b, 1'h1);
      chk("bus_tx", bus_tx_dom, 1'h0);
      cyc(1); bus_rx <= 1'h1; tx_req <= 1'h1;
      cyc(5); bus_rx <= 1'h0;
      cyc(300); bus_rx <= 1'h1;
      cyc(5); @(negedge core_clk);
      chk("inh_oe_b", inh_oe_b, 1'h1);
      cyc(1); bus_rx <= 1'h0;
      cyc(610); bus_rx <= 1'h1;
      cyc(3); @(negedge core_clk);
      chk("inh_oe_b", inh_oe_b, 1'h0);
      chk("rxd_pin", rxd_pin, 1'h0);
      chk("flag_oe_b", txd_flag_oe_b, 1'h1);
   endtask : t_remote

   // Cut a hang short
   initial begin
      repeat (8000) @(posedge core_clk);
      n_mismatch++;
      end_sim();
   end

   // Main sequence
   initial begin
      cyc(5); @(negedge core_clk);
      chk("inh_oe_b", inh_oe_b, 1'h0);
      chk("inh_o", inh_o, 1'h1);
      chk("rxd_oe_b", rxd_oe_b, 1'h1);
      chk("bus_tx", bus_tx_dom, 1'h0);
      chk("term", slave_term_en, 1'h1);
      cyc(1); rst_b <= 1'h1;
      t_sleep_timer();
      t_local_wake();
      t_mode_rise();
      t_receive();
      t_transmit();
      t_thermal();
      t_remote();
      end_sim();
   end
endmodule : ltmc_core_tb_top
